// *** rtl/dsrc_top.sv ***
// Purpose: strobe mapping, refresh timing, arbitration and self-refresh for area-3 DRAM
// Assumes: inputs synchronous to mclk; configuration bits held steady by software
// Notes:   pins are registered, so each pin lags the state machine by one clock
//
// Contract
// - mode 0: write strobes, CAS on read, RAS on select
// - mode 1: column strobes, WE on read pin
// - wait enable lets waits stretch all cycles
// - self-refresh entry: CAS low, then RAS low
// - standby exit returns CAS and RAS high
// - plain standby: strobes float, select/refresh high
// - self-refresh standby pin levels per strobe mode
// - runs in sleep, fully stopped in hardware standby
// - standby clears counter, configuration kept
// - first request after reset/standby does no refresh
// - each request sets compare-match flag
// - request during running refresh is dropped
// - interval set by constant and clock select
`timescale 1ns/1ps
`include "dsrc_consts.svh"

module dsrc_top #(
  parameter int CNT_W = `DSRC_CNT_W
) (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    strobe_mode,
  input  wire logic                    dynamic_mem_enable,
  input  wire logic                    pseudo_static_enable,
  input  wire logic                    refresh_cycle_enable,
  input  wire logic                    self_refresh_select,
  input  wire logic                    area3_wait_enable,
  input  wire logic                    wait_req,
  input  wire logic [CNT_W-1:0]        refresh_constant,
  input  wire logic [`DSRC_CKS_W-1:0]  clock_select,
  input  wire logic                    cmf_clear,
  input  wire logic                    sleep_mode,
  input  wire logic                    sw_standby,
  input  wire logic                    hw_standby,
  input  wire logic                    ext_bus_req,
  input  wire logic                    dma_req,
  input  wire logic                    cpu_req,
  input  wire logic                    access_area3,
  input  wire logic                    access_write,
  input  wire logic                    access_upper,
  input  wire logic                    access_lower,
  output logic                         upper_write_strobe,
  output logic                         upper_write_strobe_oe,
  output logic                         lower_write_strobe,
  output logic                         lower_write_strobe_oe,
  output logic                         read_strobe,
  output logic                         read_strobe_oe,
  output logic                         area3_select,
  output logic                         refresh_strobe_pin,
  output logic                         grant_ext,
  output logic                         grant_refresh,
  output logic                         grant_dma,
  output logic                         grant_cpu,
  output logic                         compare_match_flag,
  output logic [CNT_W-1:0]             refresh_counter
);
  import dsrc_pkg::*;

  dsrc_state_e             st;
  dsrc_state_e             next_st;
  logic [`DSRC_PRE_W-1:0]  prescale;
  logic                    armed;
  logic                    pend;
  logic                    acc_write_q;
  logic                    acc_upper_q;
  logic                    acc_lower_q;

  ////////////////////////////////////////////////////////////////////////////
  // refresh interval timer
  wire [3:0] div_exp = (clock_select == 3'h1) ? `DSRC_DIV_EXP1 :
                       (clock_select == 3'h2) ? `DSRC_DIV_EXP2 :
                       (clock_select == 3'h3) ? `DSRC_DIV_EXP3 :
                       (clock_select == 3'h4) ? `DSRC_DIV_EXP4 :
                       (clock_select == 3'h5) ? `DSRC_DIV_EXP5 :
                       (clock_select == 3'h6) ? `DSRC_DIV_EXP6 : `DSRC_DIV_EXP7;
  wire [`DSRC_PRE_W-1:0] div_mask = (12'h001 << div_exp) - 12'h001;
  // sleep_mode deliberately does not appear: the timer keeps running in sleep
  // stop in standby
  wire stopped   = hw_standby || sw_standby;
  wire tick      = !stopped && (clock_select != 3'h0) && ((prescale & div_mask) == 12'h000);
  wire match_evt = tick && (refresh_counter == refresh_constant);
  wire refresh_on = dynamic_mem_enable && !pseudo_static_enable && refresh_cycle_enable;
  wire refreshing = grant_refresh && (st != ST_IDLE);
  wire pend_set  = match_evt && armed && refresh_on && !refreshing;
  wire sleep_unused = sleep_mode;

  always_ff @(posedge mclk)
  begin
    if (!reset_n || stopped)
    begin
      prescale        <= 12'h000;
      refresh_counter <= CNT_W'(`DSRC_CNT_RST);
      armed           <= 1'b0;
    end
    else
    begin
      prescale        <= prescale + 12'h001;
      refresh_counter <= match_evt ? CNT_W'(`DSRC_CNT_RST) : (tick ? refresh_counter + 1'b1 : refresh_counter);
      armed           <= armed || match_evt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n || stopped)
      compare_match_flag <= 1'b0;
    else
      compare_match_flag <= match_evt || (compare_match_flag && !cmf_clear);
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration and bus-cycle sequencing
  wire idle_run  = (st == ST_IDLE) && !stopped;
  wire win_ext   = ext_bus_req;
  wire win_ref   = !win_ext && pend && refresh_on;
  wire win_dma   = !win_ext && !win_ref && dma_req;
  wire win_cpu   = !win_ext && !win_ref && !win_dma && cpu_req;
  wire start_cyc = win_ref || ((win_dma || win_cpu) && access_area3);
  // waits on normal and refresh cycles
  wire wait_on   = area3_wait_enable && wait_req;
  wire sr_enter  = dynamic_mem_enable && self_refresh_select;

  always_comb
  begin
    next_st = st;
    case (st)
      ST_IDLE:
        if (sw_standby && !hw_standby)
          next_st = sr_enter ? ST_SR_CAS : ST_SB_FLOAT;
        else if (idle_run && start_cyc)
          next_st = ST_T1;
      ST_T1:       next_st = ST_T2;
      ST_T2:       next_st = wait_on ? ST_TW : ST_T3;
      ST_TW:       next_st = wait_on ? ST_TW : ST_T3;
      ST_T3:       next_st = ST_IDLE;
      ST_SB_FLOAT: next_st = sw_standby ? ST_SB_FLOAT : ST_IDLE;
      ST_SR_CAS:   next_st = ST_SR_RAS;
      ST_SR_RAS:   next_st = ST_SR_HOLD;
      ST_SR_HOLD:  next_st = sw_standby ? ST_SR_HOLD : ST_IDLE;
      default:     next_st = ST_IDLE;
    endcase
    if (hw_standby)
      next_st = ST_IDLE;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      st            <= ST_IDLE;
      pend          <= 1'b0;
      grant_ext     <= 1'b0;
      grant_refresh <= 1'b0;
      grant_dma     <= 1'b0;
      grant_cpu     <= 1'b0;
      acc_write_q   <= 1'b0;
      acc_upper_q   <= 1'b0;
      acc_lower_q   <= 1'b0;
    end
    else
    begin
      st   <= next_st;
      // a new request beats the start clear, so it is not lost when a refresh starts
      pend <= !stopped && (pend_set || (pend && !(idle_run && win_ref)));
      if (idle_run)
      begin
        grant_ext     <= win_ext;
        grant_refresh <= win_ref;
        grant_dma     <= win_dma;
        grant_cpu     <= win_cpu;
        acc_write_q   <= access_write;
        acc_upper_q   <= access_upper;
        acc_lower_q   <= access_lower;
      end
      else if (stopped)
      begin
        grant_ext     <= 1'b0;
        grant_refresh <= 1'b0;
        grant_dma     <= 1'b0;
        grant_cpu     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DRAM strobe levels and pin mapping
  wire in_mid   = (st == ST_T2) || (st == ST_TW) || (st == ST_T3);
  wire in_cyc   = in_mid || (st == ST_T1);
  wire sr_ras   = (st == ST_SR_RAS) || (st == ST_SR_HOLD);
  wire sr_any   = sr_ras || (st == ST_SR_CAS);
  // refresh is CAS before RAS, access is RAS before CAS
  wire ras_low  = (in_mid || (st == ST_T1 && !grant_refresh)) || sr_ras;
  wire casu_low = (grant_refresh && in_cyc) || (!grant_refresh && in_mid && acc_upper_q) || sr_any;
  wire casl_low = (grant_refresh && in_cyc) || (!grant_refresh && in_mid && acc_lower_q) || sr_any;
  wire we_low   = !grant_refresh && in_mid && acc_write_q;
  wire m0_uws   = !(we_low && acc_upper_q);
  wire m0_lws   = !(we_low && acc_lower_q);
  wire m0_rd    = !(casu_low || casl_low);
  wire next_uws = strobe_mode ? !casu_low : m0_uws;
  wire next_lws = strobe_mode ? !casl_low : m0_lws;
  wire next_rd  = strobe_mode ? !we_low : m0_rd;
  wire next_oe  = dynamic_mem_enable && !hw_standby && (st != ST_SB_FLOAT);
  wire next_refresh_strobe_pin = !((grant_refresh && ras_low) || sr_ras);

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      upper_write_strobe    <= 1'b1;
      lower_write_strobe    <= 1'b1;
      read_strobe           <= 1'b1;
      upper_write_strobe_oe <= 1'b0;
      lower_write_strobe_oe <= 1'b0;
      read_strobe_oe        <= 1'b0;
      area3_select          <= 1'b1;
      refresh_strobe_pin    <= 1'b1;
    end
    else
    begin
      upper_write_strobe    <= next_uws;
      lower_write_strobe    <= next_lws;
      read_strobe           <= next_rd;
      upper_write_strobe_oe <= next_oe;
      lower_write_strobe_oe <= next_oe;
      read_strobe_oe        <= next_oe;
      area3_select          <= !ras_low;
      refresh_strobe_pin    <= next_refresh_strobe_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_cas_first;
    (st == ST_SR_CAS) ##1 (st == ST_SR_RAS);
  endsequence
  sequence s_pins_released;
    (st == ST_IDLE) ##1 (area3_select && (strobe_mode ? upper_write_strobe : read_strobe));
  endsequence

  a_mode0_map: assert property (!strobe_mode && in_mid && we_low && acc_upper_q && $stable(strobe_mode)
    |=> !upper_write_strobe && !area3_select) else $error("upper write not mapped in mode 0");
  a_mode1_map: assert property (strobe_mode && in_mid && we_low && $stable(strobe_mode)
    |=> !read_strobe && !area3_select) else $error("WE not on read pin in mode 1");
  a_arb_order: assert property (idle_run && !ext_bus_req && pend && refresh_on && dma_req
    |=> grant_refresh && !grant_dma) else $error("refresh lost to DMA");
  a_wait_insert: assert property (st == ST_T2 && wait_on && !hw_standby
    |=> st == ST_TW) else $error("wait state not inserted");
  a_sr_entry: assert property (st == ST_IDLE && sw_standby && !hw_standby && sr_enter
    |=> s_cas_first) else $error("self-refresh entry order wrong");
  a_sr_exit: assert property (st == ST_SR_HOLD && !sw_standby && !hw_standby
    |=> s_pins_released) else $error("strobes not released on exit");
  a_standby_float: assert property (st == ST_SB_FLOAT
    |=> !read_strobe_oe && area3_select && refresh_strobe_pin) else $error("standby pins wrong");
  a_sr_levels: assert property (st == ST_SR_HOLD && $stable(strobe_mode)
    |=> !area3_select && !refresh_strobe_pin && (read_strobe == strobe_mode)) else $error("self-refresh pins");
  a_hw_stop: assert property (hw_standby
    |=> refresh_counter == `DSRC_CNT_RST && !grant_refresh && st == ST_IDLE) else $error("not stopped");
  a_count_clear: assert property (sw_standby
    |=> refresh_counter == `DSRC_CNT_RST && !armed) else $error("counter kept in standby");
  a_first_skip: assert property (match_evt && !armed && !pend
    |=> !pend) else $error("first request refreshed");
  a_flag_set: assert property (match_evt
    |=> compare_match_flag) else $error("match flag not set");
  a_drop_busy: assert property (match_evt && refreshing && !pend
    |=> !pend) else $error("request queued during refresh");
endmodule

// *** rtl/dsrc_consts.svh ***
// Purpose: shared constants of the DRAM strobe and self-refresh control block
// Assumes: one 200 MHz clock (5 ns)
// Notes:   prescaler exponents give the counter clock as mclk / 2^exp
`ifndef DSRC_CONSTS_SVH
`define DSRC_CONSTS_SVH

`define DSRC_CLK_PERIOD_NS 5
`define DSRC_PRE_W         12
`define DSRC_CKS_W         3
`define DSRC_CNT_W         8
`define DSRC_CNT_RST       8'h00
`define DSRC_DIV_EXP1      4'h1
`define DSRC_DIV_EXP2      4'h3
`define DSRC_DIV_EXP3      4'h5
`define DSRC_DIV_EXP4      4'h7
`define DSRC_DIV_EXP5      4'h9
`define DSRC_DIV_EXP6      4'hb
`define DSRC_DIV_EXP7      4'hc

`endif

// *** rtl/dsrc_pkg.sv ***
// Purpose: types of the DRAM strobe and self-refresh control block
// Assumes: nothing beyond the constants header
// Notes:   bus-cycle and standby states share one machine
package dsrc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_TW,
    ST_T3,
    ST_SB_FLOAT,
    ST_SR_CAS,
    ST_SR_RAS,
    ST_SR_HOLD
  } dsrc_state_e;
endpackage

// *** sim/dsrc_dram_model.sv ***
// Purpose: behavioural area-3 DRAM that watches the strobe pins
// Assumes: floated strobe lines are pulled high on the board
// Notes:   counts CAS-before-RAS cycles; it drives nothing back
`timescale 1ns/1ps

module dsrc_dram_model (
  input  wire logic       mclk,
  input  wire logic       strobe_mode,
  input  wire logic       upper_pin,
  input  wire logic       lower_pin,
  input  wire logic       read_pin,
  input  wire logic       ras_n,
  input  wire logic       refresh_n,
  output logic [7:0]      cbr_count = 8'h00
);
  logic cas_n;
  logic ras_q = 1'b1;

  // column strobe moves to the lane pins in mode 1
  assign cas_n = strobe_mode ? (upper_pin & lower_pin) : read_pin;

  always @(posedge mclk)
  begin
    ras_q <= ras_n;
    if (ras_q && !ras_n && !cas_n && !refresh_n)
      cbr_count <= cbr_count + 8'h01;
  end
endmodule

// *** sim/dsrc_top_tb.sv ***
// Purpose: self-checking bench for the area-3 strobe and self-refresh block
// Assumes: pseudo-static 0 throughout; dynamic enable set once reset is released
// Notes:   inputs change on the falling edge and outputs are sampled there
`timescale 1ns/1ps

module dsrc_top_tb;
  logic       mclk = 1'b0, reset_n = 1'b0, strobe_mode = 1'b0, self_refresh_select = 1'b0;
  logic       dynamic_mem_enable = 1'b0;
  logic       area3_wait_enable = 1'b0, wait_req = 1'b0, cmf_clear = 1'b0, sleep_mode = 1'b0;
  logic       sw_standby = 1'b0, hw_standby = 1'b0, ext_bus_req = 1'b0, dma_req = 1'b0, cpu_req = 1'b0;
  logic       access_write = 1'b0, access_upper = 1'b0, access_lower = 1'b0;
  logic [7:0] refresh_constant = 8'h03;
  logic [2:0] clock_select = 3'h0;
  logic       upper_write_strobe, upper_write_strobe_oe, lower_write_strobe, lower_write_strobe_oe;
  logic       read_strobe, read_strobe_oe, area3_select, refresh_strobe_pin, compare_match_flag;
  logic       grant_ext, grant_refresh, grant_dma, grant_cpu;
  logic [7:0] refresh_counter, cbr;
  wire        uw = upper_write_strobe_oe ? upper_write_strobe : 1'b1;
  wire        lw = lower_write_strobe_oe ? lower_write_strobe : 1'b1;
  wire        rd = read_strobe_oe ? read_strobe : 1'b1;
  wire [3:0]  grants = {grant_ext, grant_refresh, grant_dma, grant_cpu};
  int         failures = 0, comparisons = 0, cycles = 0, d0, d1, d2, t1;

  always #2.5 mclk = ~mclk;

  dsrc_top dsrc_top_i (.mclk, .reset_n, .strobe_mode, .dynamic_mem_enable, .pseudo_static_enable(1'b0),
    .refresh_cycle_enable(1'b1), .self_refresh_select, .area3_wait_enable, .wait_req, .refresh_constant,
    .clock_select, .cmf_clear, .sleep_mode, .sw_standby, .hw_standby, .ext_bus_req, .dma_req, .cpu_req,
    .access_area3(1'b1), .access_write, .access_upper, .access_lower, .upper_write_strobe, .upper_write_strobe_oe,
    .lower_write_strobe, .lower_write_strobe_oe, .read_strobe, .read_strobe_oe, .area3_select, .refresh_strobe_pin,
    .grant_ext, .grant_refresh, .grant_dma, .grant_cpu, .compare_match_flag, .refresh_counter);

  dsrc_dram_model dsrc_dram_model_i (.mclk, .strobe_mode, .upper_pin(uw), .lower_pin(lw), .read_pin(rd),
    .ras_n(area3_select), .refresh_n(refresh_strobe_pin), .cbr_count(cbr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic test_done;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hung handshake must still reach the verdict
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      failures++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // seen bits: {upper, lower, read} went low while the row strobe was low
  task automatic access(input logic m, wr, up, lo, wt, input logic [2:0] exp, mask, output int d);
    logic [2:0] seen;
    seen = 3'h0;
    d = 0;
    strobe_mode = m;
    access_write = wr;
    access_upper = up;
    access_lower = lo;
    wait_req = wt;
    cpu_req = 1'b1;
    for (int i = 0; i < 20 && area3_select !== 1'b0; i++)
      cyc(1);
    cpu_req = 1'b0;
    while (area3_select === 1'b0 && d < 40)
    begin
      seen = seen | {uw === 1'b0, lw === 1'b0, rd === 1'b0};
      d++;
      if (d == 4)
        wait_req = 1'b0;
      cyc(1);
    end
    wait_req = 1'b0;
    chk(exp & mask, seen & mask);
  endtask

  task automatic prio;
    ext_bus_req = 1'b1;
    dma_req = 1'b1;
    cpu_req = 1'b1;
    for (int i = 0; i < 10 && grants === 4'h0; i++)
      cyc(1);
    chk(8'h08, grants);
    ext_bus_req = 1'b0;
    for (int i = 0; i < 20 && grant_dma !== 1'b1 && grant_cpu !== 1'b1; i++)
      cyc(1);
    chk(8'h02, grants);
    dma_req = 1'b0;
    cpu_req = 1'b0;
    cyc(20);
  endtask

  // constant 3 at mclk/2: four ticks of two clocks between matches
  task automatic timer;
    clock_select = 3'h1;
    for (int i = 0; i < 100 && compare_match_flag !== 1'b1; i++)
      cyc(1);
    t1 = cycles;
    cmf_clear = 1'b1;
    cyc(1);
    cmf_clear = 1'b0;
    cyc(3);
    chk(8'h00, cbr);
    for (int i = 0; i < 100 && compare_match_flag !== 1'b1; i++)
      cyc(1);
    chk(8'h08, 8'(cycles - t1));
    chk(8'h01, compare_match_flag);
    dma_req = 1'b1;
    cyc(1);
    chk(8'h04, grants);
    dma_req = 1'b0;
    for (int i = 0; i < 20 && cbr === 8'h00; i++)
      cyc(1);
    chk(8'h01, cbr);
    // waits hold the next refresh open across the following match
    area3_wait_enable = 1'b1;
    wait_req = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      cmf_clear = 1'b1;
      cyc(1);
      cmf_clear = 1'b0;
      for (int i = 0; i < 20 && compare_match_flag !== 1'b1; i++)
        cyc(1);
    end
    chk(8'h00, {area3_select, refresh_strobe_pin});
    wait_req = 1'b0;
    area3_wait_enable = 1'b0;
    // a queued request would refresh again before the next match
    cyc(7);
    chk(8'h02, cbr);
    clock_select = 3'h0;
    cyc(20);
  endtask

  task automatic standby(input logic m, s);
    logic cas_q;
    cas_q = 1'b1;
    strobe_mode = m;
    self_refresh_select = s;
    sw_standby = 1'b1;
    for (int i = 0; i < 20 && (s ? area3_select !== 1'b0 : read_strobe_oe !== 1'b0); i++)
    begin
      cas_q = m ? (uw & lw) : rd;
      cyc(1);
    end
    if (s)
      chk(8'h00, cas_q);
    cyc(2);
    chk(s ? (m ? 8'h04 : 8'h18) : 8'h03, s ? {uw, lw, rd, area3_select, refresh_strobe_pin}
      : {upper_write_strobe_oe, lower_write_strobe_oe, read_strobe_oe, area3_select, refresh_strobe_pin});
    chk(8'h00, refresh_counter);
    sw_standby = 1'b0;
    for (int i = 0; i < 10 && area3_select !== 1'b1; i++)
      cyc(1);
    chk(8'h03, {m ? (uw & lw) : rd, area3_select});
    cyc(4);
  endtask

  task automatic power;
    clock_select = 3'h1;
    sleep_mode = 1'b1;
    cyc(3);
    d0 = refresh_counter;
    cyc(3);
    chk(8'h01, refresh_counter !== d0[7:0]);
    hw_standby = 1'b1;
    cyc(6);
    chk(8'h00, refresh_counter);
    chk(8'h00, {upper_write_strobe_oe, lower_write_strobe_oe, read_strobe_oe});
    hw_standby = 1'b0;
    sleep_mode = 1'b0;
    clock_select = 3'h0;
    cyc(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(4);
    chk(8'h1f, {upper_write_strobe, lower_write_strobe, read_strobe, area3_select, refresh_strobe_pin});
    chk(8'h00, {upper_write_strobe_oe, lower_write_strobe_oe, read_strobe_oe, grants, compare_match_flag});
    reset_n = 1'b1;
    cyc(2);
    chk(8'h00, {upper_write_strobe_oe, lower_write_strobe_oe, read_strobe_oe});
    // dram mode switched on only after reset is released, before the timer set-up
    dynamic_mem_enable = 1'b1;
    cyc(2);
    access(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'b110, 3'b110, d0);
    access(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'b001, 3'b111, d0);
    access(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'b101, 3'b111, d0);
    access(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'b010, 3'b111, d0);
    access(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'b010, 3'b111, d1);
    chk(d0[7:0], d1[7:0]);
    area3_wait_enable = 1'b1;
    access(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'b010, 3'b111, d2);
    chk(8'h01, d2 > d0);
    area3_wait_enable = 1'b0;
    prio;
    timer;
    for (int k = 0; k < 4; k++)
      standby(k[0], k[1]);
    power;
    test_done;
  end
endmodule
